// file: hdl/rps_pkg.sv
// Constants and types for the remappable pin select block
package rps_pkg;
  localparam int          SEL_W          = 6;
  localparam int          NUM_IN_REGS    = 19;
  localparam int          NUM_OUT_REGS   = 15;
  localparam int          NUM_IN_FIELDS  = 2 * NUM_IN_REGS;
  localparam int          NUM_OUT_FIELDS = 2 * NUM_OUT_REGS;
  localparam int          NUM_PINS       = 33;
  localparam int          NUM_FUNCS      = 32;
  localparam int          ADDR_W         = 12;
  localparam int          IDX_W          = 5;
  localparam logic [11:0] OSC_ADDR       = 12'h000;
  localparam logic [11:0] IN_BASE        = 12'h100;
  localparam logic [11:0] OUT_BASE       = 12'h180;
  localparam logic [5:0]  IN_SEL_RST     = 6'h3F;
  localparam logic [5:0]  OUT_SEL_RST    = 6'h00;
  localparam logic [5:0]  OUT_SEL_NULL   = 6'h00;
  localparam logic        LOCK_RST       = 1'b0;
  localparam int          LOCK_BIT       = 6;
  localparam int          ARMED_BIT      = 8;
  localparam int          HI_LSB         = 8;
  localparam int          LO_LSB         = 0;
  localparam logic [7:0]  UNLOCK_KEY1    = 8'h46;
  localparam logic [7:0]  UNLOCK_KEY2    = 8'h57;

  typedef enum logic [1:0] {
    SEQ_IDLE  = 2'b00,
    SEQ_KEY1  = 2'b01,
    SEQ_ARMED = 2'b10
  } rps_seq_type;

  typedef enum logic [1:0] {
    HIT_NONE = 2'b00,
    HIT_OSC  = 2'b01,
    HIT_IN   = 2'b10,
    HIT_OUT  = 2'b11
  } rps_hit_type;
endpackage

// file: hdl/rps_route.sv
// Selector-driven routing between remappable pins and peripherals
`timescale 1ns/1ps
module rps_route (
  input  wire logic                                                 pclk,
  input  wire logic                                                 presetn,
  input  wire logic [rps_pkg::NUM_PINS-1:0]                         pin_s,
  input  wire logic [rps_pkg::NUM_PINS-1:0]                         pin_analog,
  input  wire logic [rps_pkg::NUM_IN_FIELDS-1:0][rps_pkg::SEL_W-1:0]  in_sel,
  input  wire logic [rps_pkg::NUM_OUT_FIELDS-1:0][rps_pkg::SEL_W-1:0] out_sel,
  input  wire logic [rps_pkg::NUM_FUNCS-1:0]                        periph_out,
  output logic      [rps_pkg::NUM_IN_FIELDS-1:0]                    periph_in,
  output logic      [rps_pkg::NUM_OUT_FIELDS-1:0]                   pin_out
);
  logic [rps_pkg::NUM_IN_FIELDS-1:0]  pin_in_nxt;
  logic [rps_pkg::NUM_OUT_FIELDS-1:0] pin_out_nxt;

  // Analog pins have no digital input path; selection does not change that
  always_comb begin
    for (int i = 0; i < rps_pkg::NUM_IN_FIELDS; i++) begin
      pin_in_nxt[i] = 1'b0;
      if (in_sel[i] < 6'(rps_pkg::NUM_PINS)) begin // RULE17
        pin_in_nxt[i] = pin_s[in_sel[i]] & ~pin_analog[in_sel[i]]; // RULE7
      end
    end
  end

  // Only data is routed; pad direction and peripheral enables are owned elsewhere
  always_comb begin
    for (int j = 0; j < rps_pkg::NUM_OUT_FIELDS; j++) begin
      pin_out_nxt[j] = 1'b0;
      if (out_sel[j] != rps_pkg::OUT_SEL_NULL) begin // RULE2
        pin_out_nxt[j] = periph_out[out_sel[j][4:0]]; // RULE5 RULE6
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      periph_in <= '0;
      pin_out   <= '0;
    end else begin
      periph_in <= pin_in_nxt;
      pin_out   <= pin_out_nxt;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  ground_tie_a: assert property ( // RULE17
    in_sel[1] >= 6'(rps_pkg::NUM_PINS) |=> !periph_in[1])
    else $error("out-of-range input selector not tied low");

  in_pass_a: assert property ( // RULE7
    in_sel[0] < 6'(rps_pkg::NUM_PINS) |=>
      periph_in[0] == ($past(pin_s[in_sel[0]]) & ~$past(pin_analog[in_sel[0]])))
    else $error("input routing mismatch");

  out_null_a: assert property ( // RULE2
    out_sel[0] == rps_pkg::OUT_SEL_NULL |=> !pin_out[0])
    else $error("null output code drives pin");
endmodule

// file: hdl/rps_pin_select.sv
// Remappable pin select: APB selector registers, lock sequence and routing
// Summary of operation
// RULE1 - After reset every input selector field holds all ones, tying inputs low.
// RULE2 - After reset every output selector field is zero; no pin is driven.
// RULE3 - The lock bit leaves reset unlocked so selectors are writable at once.
// RULE4 - Selector writes take effect only while the lock bit reads zero.
// RULE5 - Routing never changes pin direction or other pad settings.
// RULE6 - Routing never enables a peripheral.
// RULE7 - Routing never overrides an analog pin nor makes it digital.
// RULE8 - There are 19 input and 15 output selector registers, 34 total.
// RULE9 - First input register bits 13 to 8 choose the irq1 input pin.
// RULE10 - First input register bits 5 to 0 choose the trigger 1 input pin.
// RULE11 - Bits 15 to 14 and 7 to 6 of input registers read zero.
// RULE12 - Software should set the lock after writing all selectors.
// RULE13 - Software should park unused inputs and null unused outputs.
// RULE14 - Lock changes only after writing 46h then 57h to the low byte.
// RULE15 - Writes while locked complete without error and change nothing.
// RULE16 - With the one-shot fuse set, a set lock cannot clear until reset.
// RULE17 - Input codes naming no implemented pin leave the input unconnected.
`timescale 1ns/1ps
module rps_pin_select (
  input  wire logic                                pclk,
  input  wire logic                                presetn,
  input  wire logic                                psel,
  input  wire logic                                penable,
  input  wire logic                                pwrite,
  input  wire logic [rps_pkg::ADDR_W-1:0]          paddr,
  input  wire logic [31:0]                         pwdata,
  input  wire logic [3:0]                          pstrb,
  output logic      [31:0]                         prdata,
  output logic                                     pready,
  output logic                                     pslverr,
  input  wire logic [rps_pkg::NUM_PINS-1:0]        pin_in,
  input  wire logic [rps_pkg::NUM_PINS-1:0]        pin_analog,
  input  wire logic                                one_shot_lock_fuse,
  input  wire logic [rps_pkg::NUM_FUNCS-1:0]       periph_out,
  output logic      [rps_pkg::NUM_IN_FIELDS-1:0]   periph_in,
  output logic      [rps_pkg::NUM_OUT_FIELDS-1:0]  pin_out,
  output logic                                     map_lock_bit
);
  logic [rps_pkg::NUM_IN_FIELDS-1:0][rps_pkg::SEL_W-1:0]  in_sel_r;
  logic [rps_pkg::NUM_OUT_FIELDS-1:0][rps_pkg::SEL_W-1:0] out_sel_r;
  logic                                                   lock_r;
  logic                                                   lock_nxt;
  rps_pkg::rps_seq_type                                   seq_r;
  rps_pkg::rps_seq_type                                   seq_nxt;
  logic [rps_pkg::NUM_PINS-1:0]                           pin_meta_r;
  logic [rps_pkg::NUM_PINS-1:0]                           pin_sync_r;
  logic                                                   fuse_meta_r;
  logic                                                   fuse_sync_r;
  logic [31:0]                                            rdata_nxt;
  rps_pkg::rps_hit_type                                   hit;
  logic [rps_pkg::IDX_W-1:0]                              idx;
  logic                                                   setup;
  logic                                                   wr_acc;
  logic                                                   sel_wr_ok;
  logic [7:0]                                             key_byte;

  // Map a byte address to the register kind it selects
  function automatic rps_pkg::rps_hit_type hit_of(input logic [rps_pkg::ADDR_W-1:0] a);
    if (a[1:0] != 2'b00) begin
      return rps_pkg::HIT_NONE;
    end else if (a == rps_pkg::OSC_ADDR) begin
      return rps_pkg::HIT_OSC;
    end else if (a >= rps_pkg::IN_BASE &&
                 a < rps_pkg::IN_BASE + 12'(4 * rps_pkg::NUM_IN_REGS)) begin // RULE8
      return rps_pkg::HIT_IN;
    end else if (a >= rps_pkg::OUT_BASE &&
                 a < rps_pkg::OUT_BASE + 12'(4 * rps_pkg::NUM_OUT_REGS)) begin // RULE8
      return rps_pkg::HIT_OUT;
    end else begin
      return rps_pkg::HIT_NONE;
    end
  endfunction

  // Register index within its bank
  function automatic logic [rps_pkg::IDX_W-1:0] idx_of(input logic [rps_pkg::ADDR_W-1:0] a,
                                                      input rps_pkg::rps_hit_type h);
    logic [rps_pkg::ADDR_W-1:0] off;
    off = '0;
    if (h == rps_pkg::HIT_IN) begin
      off = a - rps_pkg::IN_BASE;
    end else if (h == rps_pkg::HIT_OUT) begin
      off = a - rps_pkg::OUT_BASE;
    end
    return off[rps_pkg::IDX_W+1:2];
  endfunction

  // Pack two selector fields into a 16-bit register image, gaps read zero
  function automatic logic [31:0] pack_pair(input logic [5:0] hi, input logic [5:0] lo);
    logic [31:0] w;
    w = '0;
    w[rps_pkg::HI_LSB +: rps_pkg::SEL_W] = hi; // RULE9
    w[rps_pkg::LO_LSB +: rps_pkg::SEL_W] = lo; // RULE10
    return w; // RULE11
  endfunction

  assign hit       = hit_of(paddr);
  assign idx       = idx_of(paddr, hit);
  assign setup     = psel && !penable;
  assign wr_acc    = psel && penable && pwrite;
  assign sel_wr_ok = wr_acc && !lock_r; // RULE4
  assign key_byte  = pwdata[7:0];
  assign pready    = 1'b1;
  assign map_lock_bit = lock_r;

  // Pins and the fuse are asynchronous to pclk
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_meta_r  <= '0;
      pin_sync_r  <= '0;
      fuse_meta_r <= 1'b0;
      fuse_sync_r <= 1'b0;
    end else begin
      pin_meta_r  <= pin_in;
      pin_sync_r  <= pin_meta_r;
      fuse_meta_r <= one_shot_lock_fuse;
      fuse_sync_r <= fuse_meta_r;
    end
  end

  // Read data and error are settled in the setup cycle so both come from flops
  always_comb begin
    rdata_nxt = '0;
    if (hit == rps_pkg::HIT_OSC) begin
      rdata_nxt[rps_pkg::LOCK_BIT]  = lock_r;
      rdata_nxt[rps_pkg::ARMED_BIT] = (seq_r == rps_pkg::SEQ_ARMED);
    end else if (hit == rps_pkg::HIT_IN) begin
      rdata_nxt = pack_pair(in_sel_r[2*idx+1], in_sel_r[2*idx]);
    end else if (hit == rps_pkg::HIT_OUT) begin
      rdata_nxt = pack_pair(out_sel_r[2*idx+1], out_sel_r[2*idx]);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= '0;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata  <= pwrite ? 32'h0000_0000 : rdata_nxt;
      pslverr <= (hit == rps_pkg::HIT_NONE); // RULE15
    end
  end

  // Unlock sequence; any other completed write breaks it
  always_comb begin
    seq_nxt = seq_r;
    if (wr_acc) begin
      seq_nxt = rps_pkg::SEQ_IDLE;
      if (hit == rps_pkg::HIT_OSC && pstrb[0]) begin
        case (seq_r)
          rps_pkg::SEQ_IDLE: begin
            if (key_byte == rps_pkg::UNLOCK_KEY1) begin
              seq_nxt = rps_pkg::SEQ_KEY1; // RULE14
            end
          end
          rps_pkg::SEQ_KEY1: begin
            if (key_byte == rps_pkg::UNLOCK_KEY2) begin
              seq_nxt = rps_pkg::SEQ_ARMED; // RULE14
            end else if (key_byte == rps_pkg::UNLOCK_KEY1) begin
              seq_nxt = rps_pkg::SEQ_KEY1;
            end
          end
          default: seq_nxt = rps_pkg::SEQ_IDLE;
        endcase
      end
    end
  end

  always_comb begin
    lock_nxt = lock_r;
    if (wr_acc && hit == rps_pkg::HIT_OSC && pstrb[0] && seq_r == rps_pkg::SEQ_ARMED) begin
      lock_nxt = pwdata[rps_pkg::LOCK_BIT]; // RULE14
      if (fuse_sync_r && lock_r) begin
        lock_nxt = 1'b1; // RULE16
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seq_r  <= rps_pkg::SEQ_IDLE;
      lock_r <= rps_pkg::LOCK_RST; // RULE3
    end else begin
      seq_r  <= seq_nxt;
      lock_r <= lock_nxt;
    end
  end

  // Locked writes still complete normally on the bus
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_sel_r <= {rps_pkg::NUM_IN_FIELDS{rps_pkg::IN_SEL_RST}}; // RULE1
    end else if (sel_wr_ok && hit == rps_pkg::HIT_IN) begin // RULE15
      if (pstrb[1]) begin
        in_sel_r[2*idx+1] <= pwdata[rps_pkg::HI_LSB +: rps_pkg::SEL_W]; // RULE9
      end
      if (pstrb[0]) begin
        in_sel_r[2*idx] <= pwdata[rps_pkg::LO_LSB +: rps_pkg::SEL_W]; // RULE10
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_sel_r <= {rps_pkg::NUM_OUT_FIELDS{rps_pkg::OUT_SEL_RST}}; // RULE2
    end else if (sel_wr_ok && hit == rps_pkg::HIT_OUT) begin // RULE4
      if (pstrb[1]) begin
        out_sel_r[2*idx+1] <= pwdata[rps_pkg::HI_LSB +: rps_pkg::SEL_W];
      end
      if (pstrb[0]) begin
        out_sel_r[2*idx] <= pwdata[rps_pkg::LO_LSB +: rps_pkg::SEL_W];
      end
    end
  end

  // No direction, analog or enable outputs exist, by design
  rps_route u_route ( // RULE5 RULE6 RULE7
    .pclk       (pclk),
    .presetn    (presetn),
    .pin_s      (pin_sync_r),
    .pin_analog (pin_analog),
    .in_sel     (in_sel_r),
    .out_sel    (out_sel_r),
    .periph_out (periph_out),
    .periph_in  (periph_in),
    .pin_out    (pin_out)
  );

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  lock_guard_a: assert property ( // RULE4
    lock_r |=> $stable(in_sel_r) && $stable(out_sel_r))
    else $error("selector changed while locked");

  unlock_order_a: assert property ( // RULE14
    lock_r != $past(lock_r) |-> $past(seq_r) == rps_pkg::SEQ_ARMED)
    else $error("lock changed without key sequence");

  key_steps_a: assert property ( // RULE14
    wr_acc && hit == rps_pkg::HIT_OSC && pstrb[0] && seq_r == rps_pkg::SEQ_IDLE
      && key_byte == rps_pkg::UNLOCK_KEY1 |=> seq_r == rps_pkg::SEQ_KEY1)
    else $error("first key not recognised");

  fuse_hold_a: assert property ( // RULE16
    fuse_sync_r && lock_r |=> lock_r)
    else $error("lock cleared with one-shot fuse set");

  locked_ok_a: assert property ( // RULE15
    setup && lock_r && (hit == rps_pkg::HIT_IN || hit == rps_pkg::HIT_OUT)
      |=> pready && !pslverr)
    else $error("locked selector write errored");

  unmapped_err_a: assert property (
    setup && hit == rps_pkg::HIT_NONE |=> pslverr)
    else $error("unmapped access without error");

  rsvd_zero_a: assert property ( // RULE11
    setup && !pwrite && hit == rps_pkg::HIT_IN |=>
      prdata[15:14] == 2'b00 && prdata[7:6] == 2'b00)
    else $error("reserved input register bits nonzero");

  field_map_a: assert property ( // RULE9
    setup && !pwrite && paddr == rps_pkg::IN_BASE |=>
      prdata[13:8] == in_sel_r[1] && prdata[5:0] == in_sel_r[0])
    else $error("first input register layout wrong");

  sel_write_a: assert property ( // RULE10
    sel_wr_ok && paddr == rps_pkg::IN_BASE && pstrb[0] |=>
      in_sel_r[0] == $past(pwdata[5:0]))
    else $error("unlocked selector write lost");

  ready_high_a: assert property (
    psel && penable |-> pready)
    else $error("access phase without ready");

  rdata_stand_a: assert property (
    psel && penable |=> $stable(prdata) && $stable(pslverr))
    else $error("read data moved during access");

  wr_rdata_a: assert property (
    setup && pwrite |=> prdata == 32'h0000_0000)
    else $error("write cycle returned read data");

  upper_zero_a: assert property ( // RULE11
    setup && !pwrite |=> prdata[31:16] == 16'h0000)
    else $error("upper read half nonzero");

  lock_read_a: assert property ( // RULE4
    setup && !pwrite && hit == rps_pkg::HIT_OSC |=>
      prdata[rps_pkg::LOCK_BIT] == $past(lock_r))
    else $error("lock bit read wrong");

  mapped_ok_a: assert property (
    setup && hit != rps_pkg::HIT_NONE |=> !pslverr)
    else $error("mapped access errored");

  lock_keep_a: assert property ( // RULE14
    !(wr_acc && hit == rps_pkg::HIT_OSC) |=> $stable(lock_r))
    else $error("lock changed without control write");

  seq_hold_a: assert property ( // RULE14
    !wr_acc |=> $stable(seq_r))
    else $error("key sequence moved without write");

  key_two_a: assert property ( // RULE14
    wr_acc && hit == rps_pkg::HIT_OSC && pstrb[0] && seq_r == rps_pkg::SEQ_KEY1
      && key_byte == rps_pkg::UNLOCK_KEY2 |=> seq_r == rps_pkg::SEQ_ARMED)
    else $error("second key not recognised");

  seq_break_a: assert property ( // RULE14
    wr_acc && hit != rps_pkg::HIT_OSC |=> seq_r == rps_pkg::SEQ_IDLE)
    else $error("other write kept key sequence");

  lock_load_a: assert property ( // RULE14
    wr_acc && hit == rps_pkg::HIT_OSC && pstrb[0] && seq_r == rps_pkg::SEQ_ARMED
      && !(fuse_sync_r && lock_r) |=> lock_r == $past(pwdata[rps_pkg::LOCK_BIT]))
    else $error("armed write did not load lock");

  lock_rst_a: assert property ( // RULE3
    $rose(presetn) |-> lock_r == rps_pkg::LOCK_RST)
    else $error("lock not clear after reset");

  in_rst_a: assert property ( // RULE1
    $rose(presetn) |->
      in_sel_r == {rps_pkg::NUM_IN_FIELDS{rps_pkg::IN_SEL_RST}})
    else $error("input selectors not all ones after reset");

  out_rst_a: assert property ( // RULE2
    $rose(presetn) |->
      out_sel_r == {rps_pkg::NUM_OUT_FIELDS{rps_pkg::OUT_SEL_RST}})
    else $error("output selectors not zero after reset");

  hi_write_a: assert property ( // RULE9
    sel_wr_ok && paddr == rps_pkg::IN_BASE && pstrb[1] |=>
      in_sel_r[1] == $past(pwdata[rps_pkg::HI_LSB +: rps_pkg::SEL_W]))
    else $error("high selector field write lost");

  hi_keep_a: assert property ( // RULE10
    sel_wr_ok && paddr == rps_pkg::IN_BASE && !pstrb[1] |=> $stable(in_sel_r[1]))
    else $error("low byte write disturbed high field");

  bad_write_a: assert property (
    wr_acc && hit == rps_pkg::HIT_NONE |=> $stable(in_sel_r) && $stable(out_sel_r))
    else $error("unmapped write changed a selector");

  bad_read_a: assert property (
    setup && !pwrite && hit == rps_pkg::HIT_NONE |=> prdata == 32'h0000_0000)
    else $error("unmapped read returned data");

  out_write_a: assert property ( // RULE4
    sel_wr_ok && paddr == rps_pkg::OUT_BASE && pstrb[0] |=>
      out_sel_r[0] == $past(pwdata[rps_pkg::LO_LSB +: rps_pkg::SEL_W]))
    else $error("unlocked output selector write lost");
endmodule

// file: tb/rps_far_model.sv
// Behavioural model of the pads and peripherals around the pin select block
`timescale 1ns/1ps
module rps_far_model (
  input  wire logic                          pclk,
  input  wire logic [rps_pkg::NUM_PINS-1:0]  pin_set,
  input  wire logic [rps_pkg::NUM_PINS-1:0]  ana_set,
  input  wire logic [rps_pkg::NUM_FUNCS-1:0] func_set,
  output logic      [rps_pkg::NUM_PINS-1:0]  pin_in,
  output logic      [rps_pkg::NUM_PINS-1:0]  pin_analog,
  output logic      [rps_pkg::NUM_FUNCS-1:0] periph_out
);
  // Pads idle high so a tied-low input is told apart from a routed pin
  logic [rps_pkg::NUM_PINS-1:0]  pin_r  = '1;
  logic [rps_pkg::NUM_PINS-1:0]  ana_r  = '0;
  logic [rps_pkg::NUM_FUNCS-1:0] func_r = '1;

  // Levels move just after an edge, never on it
  always @(posedge pclk) begin
    pin_r  <= pin_set;
    ana_r  <= ana_set;
    func_r <= func_set;
  end

  assign pin_in     = pin_r;
  assign pin_analog = ana_r;
  assign periph_out = func_r;
endmodule

// file: tb/rps_pin_select_tb.sv
// Self-checking bench for the remappable pin select block
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin miscompares++; \
  $display("unexpected at %0t: got %h want %h", $time, g, e); end end
module rps_pin_select_tb;
  logic                          pclk     = 1'b0;
  logic                          presetn  = 1'b0;
  logic                          psel     = 1'b0;
  logic                          penable  = 1'b0;
  logic                          pwrite   = 1'b0;
  logic [11:0]                   paddr    = 12'h000;
  logic [31:0]                   pwdata   = 32'h0;
  logic [3:0]                    pstrb    = 4'h0;
  logic                          fuse     = 1'b0;
  logic [rps_pkg::NUM_PINS-1:0]  pin_set  = '1;
  logic [rps_pkg::NUM_PINS-1:0]  ana_set  = '0;
  logic [rps_pkg::NUM_FUNCS-1:0] func_set = '1;
  logic [rps_pkg::NUM_PINS-1:0]  pin_in;
  logic [rps_pkg::NUM_PINS-1:0]  pin_analog;
  logic [rps_pkg::NUM_FUNCS-1:0] periph_out;
  logic [31:0]                   prdata;
  logic                          pready;
  logic                          pslverr;
  logic [37:0]                   periph_in;
  logic [29:0]                   pin_out;
  logic                          map_lock_bit;
  logic [31:0]                   rd;
  logic                          er;
  int                            miscompares = 0;
  int                            checked     = 0;

  always #2 pclk = ~pclk;

  rps_far_model far (.pclk(pclk), .pin_set(pin_set), .ana_set(ana_set), .func_set(func_set),
    .pin_in(pin_in), .pin_analog(pin_analog), .periph_out(periph_out));

  rps_pin_select uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pin_in(pin_in), .pin_analog(pin_analog),
    .one_shot_lock_fuse(fuse), .periph_out(periph_out), .periph_in(periph_in),
    .pin_out(pin_out), .map_lock_bit(map_lock_bit));

  task automatic test_done();
    if (miscompares == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= w ? s : 4'h0;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      $display("unexpected at %0t: no ready", $time);
      miscompares++;
      test_done();
    end
  endtask

  // Key bytes go to the low byte only, as a byte-wide write would
  task automatic lock_seq(input logic [7:0] v);
    apb(1'b1, rps_pkg::OSC_ADDR, 32'h46, 4'h1);
    apb(1'b1, rps_pkg::OSC_ADDR, 32'h57, 4'h1);
    apb(1'b1, rps_pkg::OSC_ADDR, {24'h0, v}, 4'h1);
    @(negedge pclk);
  endtask

  // Pin to peripheral path: model register, two sync stages, route register
  task automatic settle();
    repeat (6) @(posedge pclk);
    @(negedge pclk);
  endtask

  task automatic t_reset();
    @(negedge pclk);
    `CHK(map_lock_bit, 1'b0)
    `CHK(periph_in, 38'h0)
    `CHK(pin_out, 30'h0)
    for (int i = 0; i < 19; i++) begin
      apb(1'b0, rps_pkg::IN_BASE + 12'(4 * i), 32'h0, 4'h0);
      `CHK(rd, 32'h0000_3F3F)
    end
    for (int i = 0; i < 15; i++) begin
      apb(1'b0, rps_pkg::OUT_BASE + 12'(4 * i), 32'h0, 4'h0);
      `CHK(er, 1'b0)
      `CHK(rd, 32'h0)
    end
    `CHK(periph_in, 38'h0)
    `CHK(pin_out, 30'h0)
    apb(1'b0, rps_pkg::IN_BASE + 12'h04C, 32'h0, 4'h0);
    `CHK(er, 1'b1)
    apb(1'b1, rps_pkg::IN_BASE + 12'h04C, 32'h0, 4'hF);
    `CHK(er, 1'b1)
    apb(1'b0, rps_pkg::OUT_BASE + 12'h03C, 32'h0, 4'h0);
    `CHK(er, 1'b1)
  endtask

  task automatic t_in_route();
    apb(1'b1, rps_pkg::IN_BASE, 32'hFFFF_C5C3, 4'hF);
    apb(1'b0, rps_pkg::IN_BASE, 32'h0, 4'h0);
    `CHK(rd, 32'h0000_0503)
    pin_set <= ~33'h8;
    settle();
    `CHK(periph_in[1:0], 2'b10)
    pin_set <= 33'h8;
    settle();
    `CHK(periph_in[1:0], 2'b01)
    pin_set <= '1;
    ana_set <= 33'h20;
    settle();
    `CHK(periph_in[1:0], 2'b01)
    ana_set <= '0;
    apb(1'b1, rps_pkg::IN_BASE, 32'h0000_203E, 4'hF);
    settle();
    `CHK(periph_in[1:0], 2'b10)
  endtask

  task automatic t_out_route();
    func_set <= 32'h0000_0080;
    apb(1'b1, rps_pkg::OUT_BASE, 32'h0000_0207, 4'hF);
    settle();
    `CHK(pin_out[1:0], 2'b01)
    func_set <= 32'h0000_0004;
    settle();
    `CHK(pin_out[1:0], 2'b10)
    func_set <= '1;
    apb(1'b1, rps_pkg::OUT_BASE, 32'h0, 4'hF);
    settle();
    `CHK(pin_out[1:0], 2'b00)
  endtask

  task automatic t_lock();
    lock_seq(8'h40);
    `CHK(map_lock_bit, 1'b1)
    apb(1'b0, rps_pkg::OSC_ADDR, 32'h0, 4'h0);
    `CHK(rd[6], 1'b1)
    apb(1'b1, rps_pkg::IN_BASE, 32'h0000_0101, 4'hF);
    `CHK(er, 1'b0)
    apb(1'b0, rps_pkg::IN_BASE, 32'h0, 4'h0);
    `CHK(rd, 32'h0000_203E)
    // An interrupted key sequence must not reach the lock bit
    apb(1'b1, rps_pkg::OSC_ADDR, 32'h46, 4'h1);
    apb(1'b1, rps_pkg::OSC_ADDR, 32'h00, 4'h1);
    apb(1'b1, rps_pkg::OSC_ADDR, 32'h57, 4'h1);
    apb(1'b1, rps_pkg::OSC_ADDR, 32'h00, 4'h1);
    @(negedge pclk);
    `CHK(map_lock_bit, 1'b1)
    lock_seq(8'h00);
    `CHK(map_lock_bit, 1'b0)
    apb(1'b1, rps_pkg::IN_BASE, 32'h0000_0101, 4'hF);
    apb(1'b0, rps_pkg::IN_BASE, 32'h0, 4'h0);
    `CHK(rd, 32'h0000_0101)
    apb(1'b1, rps_pkg::IN_BASE, 32'h0000_0202, 4'h1);
    apb(1'b0, rps_pkg::IN_BASE, 32'h0, 4'h0);
    `CHK(rd, 32'h0000_0102)
  endtask

  task automatic t_fuse();
    fuse <= 1'b1;
    repeat (3) @(posedge pclk);
    lock_seq(8'h40);
    lock_seq(8'h00);
    `CHK(map_lock_bit, 1'b1)
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    `CHK(map_lock_bit, 1'b0)
    apb(1'b0, rps_pkg::IN_BASE, 32'h0, 4'h0);
    `CHK(rd, 32'h0000_3F3F)
  endtask

  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_in_route();
    t_out_route();
    t_lock();
    t_fuse();
    test_done();
  end
endmodule
